// >>> mtb_channel.sv
/*
 One 16-bit timer channel with interval, event counter and pulse
 period/width measurement modes, behind an AHB-Lite slave.
 Assumes single whole-word transfers; subclock arrives synchronous.
*/
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module mtb_channel #(
	parameter bit HAS_PIN = 1'b1
) (
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        channel_input_pin_in,
	input  wire logic        subclock_div32_in,
	input  wire logic        other_timer_ovf_in,
	output logic             irq_req_out
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic        pin_s1;
		logic        pin_s2;
		logic        pin_d;
		logic [4:0]  pre;
		logic        sub_d;
		logic        start;
		logic [7:0]  mode;
		logic [15:0] reload;
		logic [15:0] count;
		logic        ovf;
		logic        ovf_armed;
		logic        seen_edge;
		logic        irq;
		logic        d_act;
		logic        d_wr;
		logic [3:0]  d_ofs;
		logic [31:0] rdata;
	} mtb_state_t;

	mtb_state_t st;
	mtb_state_t next_st;

	logic [1:0]  cur_mode;
	logic        tick;
	logic        pin_rise;
	logic        pin_fall;
	logic        ev_edge;
	logic        meas_edge;
	logic        down_mode;
	logic        wr_start;
	logic        wr_mode;
	logic        wr_value;
	logic [15:0] rd_value;

	////////////////////////////////////////////////////////////////////////
	// Decode of current state
	always_comb
	begin
		cur_mode  = st.mode[mtb_pkg::MTB_MODE_LSB +: 2];
		if (!HAS_PIN)
			cur_mode = mtb_pkg::MTB_MODE_TIMER; // [R13]
		// Mode 3 behaves as measurement, so only codes 0 and 1 count down [R1]
		down_mode = (cur_mode == mtb_pkg::MTB_MODE_TIMER) || (cur_mode == mtb_pkg::MTB_MODE_EVENT);
		pin_rise  = HAS_PIN && st.pin_s2 && !st.pin_d;
		pin_fall  = HAS_PIN && !st.pin_s2 && st.pin_d;
		// Internal source select [R2] [R14]
		case (st.mode[mtb_pkg::MTB_SRC_LSB +: 2])
			2'h0: tick = 1'b1;
			2'h1: tick = (st.pre[2:0] == 3'h7);
			2'h2: tick = (st.pre == 5'h1F);
			default: tick = subclock_div32_in && !st.sub_d;
		endcase
		// Event source: pin edges or another timer [R10] [R11]
		if (st.mode[mtb_pkg::MTB_EVSRC_BIT])
			ev_edge = other_timer_ovf_in;
		else
		begin
			case (st.mode[mtb_pkg::MTB_EDGE_LSB +: 2])
				mtb_pkg::MTB_EDGE_FALL: ev_edge = pin_fall;
				mtb_pkg::MTB_EDGE_RISE: ev_edge = pin_rise;
				default: ev_edge = pin_rise || pin_fall;
			endcase
		end
		// Measurement edge: period uses one polarity, width uses both [R22]
		if (st.mode[mtb_pkg::MTB_MEAS_BIT])
			meas_edge = pin_rise || pin_fall;
		else if (st.mode[mtb_pkg::MTB_EDGE_LSB])
			meas_edge = pin_rise;
		else
			meas_edge = pin_fall;
		wr_start = st.d_act && st.d_wr && (st.d_ofs == mtb_pkg::MTB_OFS_START);
		wr_mode  = st.d_act && st.d_wr && (st.d_ofs == mtb_pkg::MTB_OFS_MODE);
		wr_value = st.d_act && st.d_wr && (st.d_ofs == mtb_pkg::MTB_OFS_VALUE);
		// Read view of the value register [R9] [R12] [R19]
		rd_value = down_mode ? st.count : st.reload;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_st        = st;
		next_st.pin_s1 = channel_input_pin_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_d  = st.pin_s2;
		next_st.pre    = st.pre + 5'h01;
		next_st.sub_d  = subclock_div32_in;
		next_st.irq    = 1'b0;

		// Counting engine, only while started [R5]
		if (st.start)
		begin
			if (down_mode)
			begin
				if ((cur_mode == mtb_pkg::MTB_MODE_TIMER) ? tick : ev_edge)
				begin
					if (st.count == 16'h0000)
					begin
						next_st.count = st.reload; // [R3] [R4]
						next_st.irq   = 1'b1;      // [R6]
					end
					else
						next_st.count = st.count - 16'h0001; // [R3]
				end
			end
			else
			begin
				if (meas_edge)
				begin
					next_st.reload    = st.count;  // [R15]
					next_st.count     = 16'h0000;  // [R15]
					next_st.seen_edge = 1'b1;
					next_st.irq       = st.seen_edge; // [R16]
				end
				else if (tick)
				begin
					next_st.count = st.count + 16'h0001; // [R14]
					if (st.count == 16'hFFFF)
					begin
						next_st.ovf  = 1'b1; // [R17] [R23]
						next_st.irq  = 1'b1; // [R17]
					end
					if (st.ovf)
						next_st.ovf_armed = 1'b1;
				end
			end
		end

		// Overflow flag cleared by mode write after a further count cycle [R18]
		if (wr_mode)
		begin
			next_st.mode = hwdata_in[7:0];
			if (st.ovf_armed && !(next_st.ovf && !st.ovf))
			begin
				next_st.ovf       = 1'b0;
				next_st.ovf_armed = 1'b0;
			end
		end

		if (wr_start)
		begin
			next_st.start = hwdata_in[0];
			if (hwdata_in[0] && !st.start)
			begin
				next_st.seen_edge = 1'b0;
				if (!down_mode)
					next_st.count = 16'h0000;
			end
		end

		// Value register writes [R7] [R8] [R21]
		if (wr_value && down_mode)
		begin
			next_st.reload = hwdata_in[15:0];
			if (!st.start)
				next_st.count = hwdata_in[15:0]; // [R7]
		end

		// AHB-Lite address phase capture, zero wait states
		next_st.d_act = hsel_in && hready_in && htrans_in[1];
		next_st.d_wr  = hwrite_in;
		next_st.d_ofs = haddr_in[3:0];
		next_st.rdata = 32'h00000000;
		if (hsel_in && hready_in && htrans_in[1] && !hwrite_in)
		begin
			case (haddr_in[3:0])
				mtb_pkg::MTB_OFS_START:  next_st.rdata = {31'h00000000, st.start};
				mtb_pkg::MTB_OFS_MODE:   next_st.rdata = {24'h000000, st.mode[7:6], st.ovf, st.mode[4:0]};
				mtb_pkg::MTB_OFS_VALUE:  next_st.rdata = {16'h0000, rd_value};
				mtb_pkg::MTB_OFS_STATUS: next_st.rdata = {30'h00000000, st.seen_edge, st.ovf};
				default:                 next_st.rdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st        <= '0;
			st.mode   <= mtb_pkg::MTB_MODE_RST;
			st.reload <= mtb_pkg::MTB_VALUE_RST;
			st.count  <= mtb_pkg::MTB_VALUE_RST;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hrdata_out    = st.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign irq_req_out   = st.irq;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_stop_holds: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R5]
		(!st.start && !wr_value && !wr_start) |=> (st.count == $past(st.count)))
		else $error("counter moved while stopped");

	a_underflow_reload: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R3]
		(st.start && down_mode && st.count == 16'h0000 && tick && cur_mode == mtb_pkg::MTB_MODE_TIMER
		 && !wr_value && !wr_mode && !wr_start) |=> (st.count == $past(st.reload) && irq_req_out))
		else $error("underflow did not reload");

	a_down_irq: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R6]
		(irq_req_out && $past(down_mode) && !$past(wr_mode)) |-> ($past(st.count) == 16'h0000))
		else $error("irq without underflow");

	a_write_stopped: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R7]
		(wr_value && down_mode && !st.start && !wr_start) |=> (st.count == st.reload))
		else $error("stopped write did not load counter");

	a_write_running: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R8]
		(wr_value && down_mode && st.start && !tick && !ev_edge && !wr_mode) |=> (st.count == $past(st.count)))
		else $error("running write touched counter");

	a_meas_capture: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R15]
		(st.start && !down_mode && meas_edge && !wr_start && !wr_mode)
		|=> (st.count == 16'h0000 && st.reload == $past(st.count)))
		else $error("measurement edge did not capture");

	a_first_edge: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R16]
		(st.start && !down_mode && meas_edge && !st.seen_edge && !wr_mode) |=> !irq_req_out)
		else $error("first edge raised irq");

	a_meas_ovf: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R17]
		(st.start && !down_mode && !meas_edge && tick && st.count == 16'hFFFF && !wr_mode && !wr_start)
		|=> (st.ovf && irq_req_out))
		else $error("overflow not flagged");

	a_meas_nowrite: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R21]
		(wr_value && !down_mode && !st.start && !wr_mode && !wr_start) |=> (st.reload == $past(st.reload)))
		else $error("measurement accepted a value write");

	a_read_view: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R19]
		(hsel_in && hready_in && htrans_in[1] && !hwrite_in && haddr_in[3:0] == mtb_pkg::MTB_OFS_VALUE)
		|=> (hrdata_out[15:0] == ($past(down_mode) ? $past(st.count) : $past(st.reload))))
		else $error("wrong value read view");

	// Down-counting modes never raise the overflow flag
	a_down_no_ovf: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R1]
		(down_mode && !st.ovf && !wr_mode) |=> !st.ovf)
		else $error("overflow flag set in down mode");

	// Timer tick above zero takes exactly one count off
	a_timer_tick: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R2]
		(st.start && cur_mode == mtb_pkg::MTB_MODE_TIMER && tick && st.count != 16'h0000
		 && !wr_value && !wr_start && !wr_mode) |=> (st.count == $past(st.count) - 16'h0001))
		else $error("timer tick did not decrement");

	// Event edge above zero takes exactly one count off
	a_event_step: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R10]
		(st.start && cur_mode == mtb_pkg::MTB_MODE_EVENT && ev_edge && st.count != 16'h0000
		 && !wr_value && !wr_start && !wr_mode) |=> (st.count == $past(st.count) - 16'h0001))
		else $error("event edge did not decrement");

	// Armed overflow flag drops on a mode write unless a new overflow lands
	a_ovf_clear: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // [R18]
		(wr_mode && st.ovf_armed && !(st.start && !down_mode && tick && !meas_edge && st.count == 16'hFFFF))
		|=> !st.ovf)
		else $error("overflow flag not cleared");

endmodule // mtb_channel

`default_nettype wire

// >>> mtb_pkg.sv
/*
 Constants for the multimode timer channel: register offsets, field positions,
 reset values and mode encodings. Assumes a 32-bit AHB-Lite register bus.
*/
// Functional notes
// R1 - Mode register bits 1:0 choose interval, event counter or measurement mode.
// R2 - Interval mode counts one of undivided, div8, div32 or subclock div32 sources.
// R3 - Down-counting modes decrement and reload from reload register on underflow.
// R4 - Underflow period is programmed value plus one source cycles.
// R5 - Counter runs only while start flag is one.
// R6 - Down-counting modes raise interrupt request on every underflow.
// R7 - Value write while stopped loads reload register and counter.
// R8 - Value write while counting loads only reload register.
// R9 - Interval mode reads return the counter; pin stays a plain port.
// R10 - Event mode counts pin transitions or another timer's overflow.
// R11 - Event mode edge select: rising, falling or both.
// R12 - Event mode reads return the counter.
// R13 - Channel without input pin is interval timer only, no measurement.
// R14 - Measurement mode counts up on one of the four internal sources.
// R15 - Measurement edge copies counter to reload, restarts from zero.
// R16 - Measurement edges request interrupt except the first after start.
// R17 - Measurement overflow requests interrupt and sets overflow flag.
// R18 - Mode register write after next count cycle clears overflow flag.
// R19 - Measurement mode reads return the reload register.
// R20 - Software ignores results before the second effective edge.
// R21 - Measurement mode ignores value register writes.
// R22 - Period measurement spans consecutive edges of the same polarity.
// R23 - Counter, reload and value register are 16 bits; overflow past all-ones.
`default_nettype none

package mtb_pkg;

	// Register byte offsets
	localparam logic [3:0] MTB_OFS_START  = 4'h0;
	localparam logic [3:0] MTB_OFS_MODE   = 4'h4;
	localparam logic [3:0] MTB_OFS_VALUE  = 4'h8;
	localparam logic [3:0] MTB_OFS_STATUS = 4'hC;

	// Mode register fields
	localparam int MTB_MODE_LSB = 0;
	localparam int MTB_EDGE_LSB = 2;
	localparam int MTB_MEAS_BIT = 3;
	localparam int MTB_EVSRC_BIT = 4;
	localparam int MTB_SRC_LSB  = 6;
	localparam int MTB_OVF_BIT  = 5;

	// Operating modes
	localparam logic [1:0] MTB_MODE_TIMER = 2'h0;
	localparam logic [1:0] MTB_MODE_EVENT = 2'h1;
	localparam logic [1:0] MTB_MODE_MEAS  = 2'h2;

	// Event edge select
	localparam logic [1:0] MTB_EDGE_FALL = 2'h0;
	localparam logic [1:0] MTB_EDGE_RISE = 2'h1;
	localparam logic [1:0] MTB_EDGE_BOTH = 2'h2;

	// Reset values
	localparam logic [7:0]  MTB_MODE_RST  = 8'h00;
	localparam logic [15:0] MTB_VALUE_RST = 16'h0000;

	// Prescaler ratios
	localparam int MTB_DIV8  = 8;
	localparam int MTB_DIV32 = 32;

endpackage

`default_nettype wire

// >>> mtb_pulse_src.sv
/*
 Pulse source model on the channel input pin.
 Assumes the bench clock; square wave of two equal halves.
*/
`timescale 1ns/1ps
`default_nettype none

module mtb_pulse_src (
	input  wire logic       clk_in,
	input  wire logic       en_in,
	input  wire logic [7:0] half_in,
	output logic            pin_out
);
	logic [7:0] cnt = 8'h00;

	// Toggle every half period, idle low when disabled
	always @(posedge clk_in)
	begin
		if (!en_in)
		begin
			cnt <= 8'h00;
			pin_out <= 1'b0;
		end
		else if (cnt + 8'h01 >= half_in)
		begin
			cnt <= 8'h00;
			pin_out <= ~pin_out;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule // mtb_pulse_src

`default_nettype wire

// >>> mtb_channel_tb.sv
/*
 Self-checking bench for the timer channel.
 Assumes a zero-wait AHB-Lite slave and the pulse source model.
*/
`timescale 1ns/1ps
`default_nettype none

module mtb_channel_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hrdy;
	logic        pin;
	logic        sub = 1'b0;
	logic        ovf = 1'b0;
	logic        irq;
	logic        src_en = 1'b0;
	logic [7:0]  half = 8'h03;
	logic        rdp = 1'b0;
	logic [31:0] expq[$];
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          t0;
	int          t1;
	int          n;
	int          divs[4] = '{1, 8, 32, 4};
	int          evx[4] = '{18, 18, 9, 15};

	always #10 clk = ~clk;

	mtb_channel uut (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
		.hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(), .channel_input_pin_in(pin),
		.subclock_div32_in(sub), .other_timer_ovf_in(ovf), .irq_req_out(irq));

	mtb_pulse_src psrc (.clk_in(clk), .en_in(src_en), .half_in(half), .pin_out(pin));

	////////////////////////////////////////////////////////////////
	// Side sources and read-data scoreboard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sub <= (cyc % 4) < 2;
		ovf <= (cyc % 5) == 0;
		if (rdp && hrdy === 1'b1)
		begin
			check_count++;
			if (hrdata !== expq[0])
				fail("read data mismatch");
			void'(expq.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////
	task fail(input string m);
		num_errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	task final_report;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Wait for a bus or irq signal, bounded
	task wsig(input int lim, input bit use_irq);
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while ((use_irq ? irq : hrdy) !== 1'b1 && k < lim);
		if ((use_irq ? irq : hrdy) !== 1'b1)
		begin
			fail("wait ran out");
			final_report;
		end
	endtask

	// One single transfer; read expectation queued
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wsig(100, 0);
		htrans <= 2'h0;
		hwdata <= d;
		rdp <= !wr;
		if (!wr)
			expq.push_back(e);
		wsig(100, 0);
		rdp <= 1'b0;
	endtask

	// Interval between two interrupt pulses
	task per(input int e);
		wsig(70000, 1);
		t0 = cyc;
		wsig(70000, 1);
		t1 = cyc;
		check_count++;
		if (t1 - t0 != e)
			fail("interrupt interval");
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(70822));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(0, 8'h04, 0, 0);
		bus(0, 8'h10, 0, 0);
		for (int s = 0; s < 4; s++)
		begin
			n = $urandom_range(5, 1);
			bus(1, 8'h00, 0, 0);
			bus(1, 8'h04, s << 6, 0);
			bus(1, 8'h08, n, 0);
			bus(0, 8'h08, 0, n);
			bus(1, 8'h00, 1, 0);
			per((n + 1) * divs[s]);
		end
		$display("interval test done");
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h04, 0, 0);
		bus(1, 8'h08, 5, 0);
		bus(1, 8'h00, 1, 0);
		wsig(100, 1);
		bus(1, 8'h08, 2, 0);
		per(3);
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h08, 7, 0);
		repeat (10) @(posedge clk);
		bus(0, 8'h08, 0, 7);
		$display("reload test done");
		src_en <= 1'b1;
		for (int g = 0; g < 4; g++)
		begin
			bus(1, 8'h00, 0, 0);
			bus(1, 8'h04, g < 3 ? {g[1:0], 2'h1} : 8'h11, 0);
			bus(1, 8'h08, 2, 0);
			bus(0, 8'h08, 0, 2);
			bus(1, 8'h00, 1, 0);
			per(evx[g]);
		end
		$display("event test done");
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h04, 8'h02, 0);
		bus(1, 8'h00, 1, 0);
		wsig(100, 1);
		bus(0, 8'h08, 0, 5);
		per(6);
		bus(1, 8'h08, 16'h1234, 0);
		bus(0, 8'h08, 0, 5);
		bus(1, 8'h04, 8'h0A, 0);
		per(3);
		bus(0, 8'h08, 0, 2);
		$display("measure test done");
		src_en <= 1'b0;
		bus(1, 8'h00, 0, 0);
		bus(1, 8'h04, 8'h02, 0);
		bus(1, 8'h00, 1, 0);
		t0 = cyc;
		wsig(70000, 1);
		check_count++;
		if (cyc - t0 < 65530 || cyc - t0 > 65540)
			fail("overflow time");
		bus(0, 8'h0C, 0, 1);
		repeat (3) @(posedge clk);
		bus(1, 8'h04, 8'h02, 0);
		bus(0, 8'h0C, 0, 0);
		$display("overflow test done");
		final_report;
	end
endmodule // mtb_channel_tb

`default_nettype wire
